// >>> common/rtp_pkg.sv
// constants, register map and types of the record transmit path
package rtp_pkg;
    // ------------------------------------------------------------
    // clock and card time
    // ------------------------------------------------------------
    localparam int          CLK_HZ    = 25_000_000;
    localparam logic [63:0] TIME_STEP = 64'((64'h1 << 32) / CLK_HZ);
    localparam logic [63:0] TIME_RST  = 64'h0;
    // ------------------------------------------------------------
    // register map, byte addresses on the bus
    // ------------------------------------------------------------
    localparam int         ADR_W        = 8;
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_DROPS    = 8'h08;
    localparam logic [7:0] OFS_MEMSPLIT = 8'h0C;
    localparam logic [7:0] OFS_TFRAC    = 8'h10;
    localparam logic [7:0] OFS_TSEC     = 8'h14;
    localparam logic [3:0] IDX_NONE     = 4'hF;
    // control bits
    localparam int CTRL_TX_EN  = 0;
    localparam int CTRL_STRIP  = 1;
    localparam int CTRL_APPEND = 2;
    localparam int CTRL_DROP   = 3;
    localparam int CTRL_TIMED  = 4;
    localparam int CTRL_W      = 5;
    localparam logic [4:0] CTRL_RST = 5'h00;
    // status bits
    localparam int ST_UNDERRUN = 0;
    // memory split in megabytes
    localparam logic [7:0] MEM_TOTAL_MB = 8'hFF;
    localparam logic [7:0] TX_MB_RST    = 8'h10;
    // ------------------------------------------------------------
    // record layout, 64-bit words
    // ------------------------------------------------------------
    localparam int          PORTS      = 4;
    localparam int          PORT_W     = 2;
    localparam int          FLAG_LSB   = 8;
    localparam int          RXERR_BIT  = 12;
    localparam int          RLEN_LSB   = 16;
    localparam int          WLEN_LSB   = 32;
    localparam logic [12:0] HDR_WORDS  = 13'h2;
    localparam logic [15:0] FCS_BYTES  = 16'h4;
    // ------------------------------------------------------------
    // check sequence
    // ------------------------------------------------------------
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [2:0]  CRC_BYTES = 3'h4;
    // ------------------------------------------------------------
    // transfer states, gray along the timed path
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        RTP_IDLE = 3'h0,
        RTP_INFO = 3'h1,
        RTP_WAIT = 3'h3,
        RTP_PAY  = 3'h2,
        RTP_SKIP = 3'h6
    } rtp_state_t;
endpackage

// >>> common/rtp_byte_if.sv
// byte stream from the record engine to the check sequence stage
interface rtp_byte_if;
    logic [7:0] data;
    logic       valid;
    logic       last;
    logic       append;
    logic [1:0] port;
    logic       ready;
    modport src (output data, output valid, output last, output append, output port, input ready);
    modport snk (input data, input valid, input last, input append, input port, output ready);
endinterface

// >>> rtl/rtp_mac_crc.sv
// byte-serial mac stage with optional hardware check sequence
module rtp_mac_crc
    import rtp_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // bytes from the record engine
    rtp_byte_if.snk         in,
    // mac pins
    output logic [7:0]      mac_data,
    output logic            mac_valid,
    output logic            mac_last,
    output logic [1:0]      mac_port,
    input  wire logic       mac_ready
);
    import rtp_pkg::*;

    typedef struct packed {
        logic [31:0] crc;
        logic [7:0]  data;
        logic        valid;
        logic        last;
        logic [1:0]  port;
        logic [2:0]  tail;
    } rtp_mac_t;

    rtp_mac_t r_reg;
    rtp_mac_t r_next;

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] x;
        x = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction

    assign in.ready = (r_reg.tail == 3'h0) && (!r_reg.valid || mac_ready);

    always_comb begin
        r_next = r_reg;
        if (r_reg.valid && mac_ready) begin
            r_next.valid = 1'b0;
        end
        if (in.valid && in.ready) begin
            r_next.data  = in.data;
            r_next.valid = 1'b1;
            r_next.port  = in.port;
            r_next.crc   = crc_byte(r_reg.crc, in.data);
            r_next.last  = in.last & ~in.append;
            if (in.last) begin
                if (in.append) begin
                    r_next.tail = CRC_BYTES;
                end else begin
                    r_next.crc = CRC_INIT;
                end
            end
        end else if (r_reg.tail != 3'h0 && (!r_reg.valid || mac_ready)) begin
            r_next.data  = ~r_reg.crc[7:0];
            r_next.crc   = r_reg.crc >> 8;
            r_next.valid = 1'b1;
            r_next.last  = (r_reg.tail == 3'h1);
            r_next.tail  = r_reg.tail - 3'h1;
            if (r_reg.tail == 3'h1) begin
                r_next.crc = CRC_INIT;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_reg <= '{crc: CRC_INIT, data: 8'h00, valid: 1'b0, last: 1'b0, port: 2'h0, tail: 3'h0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign mac_data  = r_reg.data;
    assign mac_valid = r_reg.valid;
    assign mac_last  = r_reg.last;
    assign mac_port  = r_reg.port;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    crc_tail_a: assert property ((in.valid && in.ready && in.last && in.append) |=> r_reg.tail == 3'h4)
        else $error("check sequence tail not started");
    no_append_a: assert property ((in.valid && in.ready && in.last && !in.append)
        |=> mac_last && r_reg.tail == 3'h0)
        else $error("bytes appended although append is off");
endmodule

// >>> rtl/rtp_top.sv
// record transmit path: wishbone registers, record engine and mac stage
//
// Summary of operation
// - strip option removes the last four bytes of each record payload
// - append option makes the mac add a computed 32-bit check sequence
// - strip plus append always yields a correct check sequence
// - no strip, no append sends original bytes, even bad ones
// - drop option discards records flagged with receive error
// - one record at a time goes to one port, in stream order
// - a stalled port only delays timing; transmission continues afterwards
// - transmit memory share resets to 16 MB, rest to receive
// - memory split changes only while both directions idle
// - receive capture runs independently while transmitting
// - only frames from the stream are ever sent
// - timestamps are 64-bit seconds.fraction values, little endian
//
// The Wishbone register port and the address map were decided locally.
module rtp_top
    import rtp_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // record stream from host memory
    input  wire logic [63:0]       rec_data,
    input  wire logic              rec_valid,
    output logic                   rec_ready,
    // receive path and link pins
    input  wire logic              rx_active,
    input  wire logic [PORTS-1:0]  link_up,
    // memory split
    output logic      [7:0]        mem_tx_mb,
    output logic      [7:0]        mem_rx_mb,
    // mac pins
    output logic      [7:0]        mac_data,
    output logic                   mac_valid,
    output logic                   mac_last,
    output logic      [1:0]        mac_port,
    input  wire logic              mac_ready
);
    import rtp_pkg::*;

    typedef struct packed {
        rtp_state_t         st;
        logic [CTRL_W-1:0]  ctrl;
        logic               underrun;
        logic [15:0]        drops;
        logic [7:0]         tx_mb;
        logic [7:0]         rx_mb;
        logic [63:0]        now;
        logic               ack;
        logic [31:0]        rdat;
        logic [63:0]        ts;
        logic [63:0]        word;
        logic               have;
        logic [2:0]         bidx;
        logic [15:0]        words_left;
        logic [15:0]        send_left;
        logic               in_frame;
        logic [1:0]         port;
        logic [PORTS-1:0]   link_s1;
        logic [PORTS-1:0]   link_s2;
    } rtp_main_t;

    rtp_main_t r_reg;
    rtp_main_t r_next;

    rtp_byte_if bq ();

    logic        req;
    logic        wr;
    logic        busy;
    logic        under_ev;
    logic        drop_ev;
    logic [3:0]  idx;
    logic [15:0] rl;
    logic [15:0] wl;
    logic [15:0] words;
    logic [15:0] sendb;
    logic [18:0] payb;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    function automatic logic [3:0] reg_index(input logic [ADR_W-1:0] a);
        case (a[ADR_W-1:2])
            OFS_CTRL[ADR_W-1:2]:     reg_index = 4'h0;
            OFS_STATUS[ADR_W-1:2]:   reg_index = 4'h1;
            OFS_DROPS[ADR_W-1:2]:    reg_index = 4'h2;
            OFS_MEMSPLIT[ADR_W-1:2]: reg_index = 4'h3;
            OFS_TFRAC[ADR_W-1:2]:    reg_index = 4'h4;
            OFS_TSEC[ADR_W-1:2]:     reg_index = 4'h5;
            default:                 reg_index = IDX_NONE;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] m;
        m = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                m[8*b +: 8] = d[8*b +: 8];
            end
        end
        return m;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        r_next    = r_reg;
        rec_ready = 1'b0;
        bq.valid  = 1'b0;
        bq.last   = 1'b0;
        under_ev  = 1'b0;
        drop_ev   = 1'b0;
        rl        = rec_data[RLEN_LSB +: 16];
        wl        = rec_data[WLEN_LSB +: 16];
        words     = (rl[15:3] >= HDR_WORDS) ? {3'h0, rl[15:3] - HDR_WORDS} : 16'h0000;
        payb      = {words, 3'h0};
        sendb     = wl;
        req       = wb_cyc_i & wb_stb_i & ~r_reg.ack;
        wr        = wb_cyc_i & wb_stb_i & wb_we_i & r_reg.ack;
        busy      = (r_reg.st != RTP_IDLE);
        idx       = reg_index(wb_adr_i);

        r_next.now     = r_reg.now + TIME_STEP;
        r_next.link_s1 = link_up;
        r_next.link_s2 = r_reg.link_s1;
        r_next.ack     = req;

        // bus read, data valid with ack
        if (req) begin
            case (idx)
                4'h0:    r_next.rdat = {27'h0000000, r_reg.ctrl};
                4'h1:    r_next.rdat = {20'h00000, r_reg.link_s2, 5'h00, rx_active, busy, r_reg.underrun};
                4'h2:    r_next.rdat = {16'h0000, r_reg.drops};
                4'h3:    r_next.rdat = {16'h0000, r_reg.rx_mb, r_reg.tx_mb};
                4'h4:    r_next.rdat = r_reg.now[31:0];
                4'h5:    r_next.rdat = r_reg.now[63:32];
                default: r_next.rdat = 32'h00000000;
            endcase
        end

        // bus write, effective at the ack edge
        if (wr) begin
            case (idx)
                4'h0: begin
                    if (wb_sel_i[0]) begin
                        r_next.ctrl = wb_dat_i[CTRL_W-1:0];
                    end
                end
                4'h3: begin
                    if (wb_sel_i[0] && !busy && !rx_active && !r_reg.ctrl[CTRL_TX_EN]) begin
                        r_next.tx_mb = wb_dat_i[7:0];
                        r_next.rx_mb = MEM_TOTAL_MB - wb_dat_i[7:0];
                    end
                end
                4'h4:    r_next.now[31:0]  = merge(r_reg.now[31:0], wb_dat_i, wb_sel_i);
                4'h5:    r_next.now[63:32] = merge(r_reg.now[63:32], wb_dat_i, wb_sel_i);
                default: r_next.ctrl = r_reg.ctrl;
            endcase
        end

        // ------------------------------------------------------------
        // record engine
        // ------------------------------------------------------------
        case (r_reg.st)
            RTP_IDLE: begin
                if (r_reg.ctrl[CTRL_TX_EN]) begin
                    rec_ready = 1'b1;
                    if (rec_valid) begin
                        r_next.ts = rec_data;
                        r_next.st = RTP_INFO;
                    end
                end
            end
            RTP_INFO: begin
                rec_ready = 1'b1;
                if (r_reg.ctrl[CTRL_STRIP]) begin
                    sendb = (wl > FCS_BYTES) ? wl - FCS_BYTES : 16'h0000;
                end
                if ({3'h0, sendb} > payb) begin
                    sendb = payb[15:0];
                end
                if (rec_valid) begin
                    r_next.words_left = words;
                    r_next.send_left  = sendb;
                    r_next.port       = rec_data[FLAG_LSB +: PORT_W];
                    r_next.have       = 1'b0;
                    r_next.bidx       = 3'h0;
                    r_next.in_frame   = 1'b0;
                    if (r_reg.ctrl[CTRL_DROP] && rec_data[RXERR_BIT]) begin
                        drop_ev   = 1'b1;
                        r_next.st = RTP_SKIP;
                    end else if (sendb == 16'h0000) begin
                        r_next.st = RTP_SKIP;
                    end else if (r_reg.ctrl[CTRL_TIMED]) begin
                        r_next.st = RTP_WAIT;
                    end else begin
                        r_next.st = RTP_PAY;
                    end
                end
            end
            RTP_WAIT: begin
                if (r_reg.now >= r_reg.ts) begin
                    r_next.st = RTP_PAY;
                end
            end
            RTP_PAY: begin
                if (!r_reg.have) begin
                    rec_ready = 1'b1;
                    if (rec_valid) begin
                        r_next.word       = rec_data;
                        r_next.have       = 1'b1;
                        r_next.bidx       = 3'h0;
                        r_next.words_left = r_reg.words_left - 16'h0001;
                    end else if (r_reg.in_frame) begin
                        under_ev = 1'b1;
                    end
                end else begin
                    bq.valid = 1'b1;
                    bq.last  = (r_reg.send_left == 16'h0001);
                    if (bq.ready) begin
                        r_next.send_left = r_reg.send_left - 16'h0001;
                        r_next.bidx      = r_reg.bidx + 3'h1;
                        r_next.in_frame  = 1'b1;
                        if (r_reg.send_left == 16'h0001) begin
                            r_next.have = 1'b0;
                            r_next.st   = (r_reg.words_left == 16'h0000) ? RTP_IDLE : RTP_SKIP;
                        end else if (r_reg.bidx == 3'h7) begin
                            r_next.have = 1'b0;
                        end
                    end
                end
            end
            RTP_SKIP: begin
                if (r_reg.words_left == 16'h0000) begin
                    r_next.st = RTP_IDLE;
                end else begin
                    rec_ready = 1'b1;
                    if (rec_valid) begin
                        r_next.words_left = r_reg.words_left - 16'h0001;
                    end
                end
            end
            default: begin
                r_next.st = RTP_IDLE;
            end
        endcase

        if (drop_ev) begin
            r_next.drops = r_reg.drops + 16'h0001;
        end
        r_next.underrun = (r_reg.underrun & ~(wr && idx == 4'h1 && wb_sel_i[0] && wb_dat_i[ST_UNDERRUN])) | under_ev;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_reg          <= '0;
            r_reg.st       <= RTP_IDLE;
            r_reg.ctrl     <= CTRL_RST;
            r_reg.tx_mb    <= TX_MB_RST;
            r_reg.rx_mb    <= MEM_TOTAL_MB - TX_MB_RST;
            r_reg.now      <= TIME_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // outputs and mac stage
    // ------------------------------------------------------------
    assign bq.data   = r_reg.word[8*r_reg.bidx +: 8];
    assign bq.append = r_reg.ctrl[CTRL_APPEND];
    assign bq.port   = r_reg.port;
    assign wb_dat_o  = r_reg.rdat;
    assign wb_ack_o  = r_reg.ack;
    assign mem_tx_mb = r_reg.tx_mb;
    assign mem_rx_mb = r_reg.rx_mb;

    rtp_mac_crc u_mac (
        .clk       (clk),
        .rst_n     (rst_n),
        .in        (bq.snk),
        .mac_data  (mac_data),
        .mac_valid (mac_valid),
        .mac_last  (mac_last),
        .mac_port  (mac_port),
        .mac_ready (mac_ready)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    strip_len_a: assert property ((r_reg.st == RTP_INFO && rec_valid && r_reg.ctrl[CTRL_STRIP]
        && wl > FCS_BYTES && {3'h0, wl} <= payb) |=> r_reg.send_left == $past(wl) - FCS_BYTES)
        else $error("strip length wrong");
    drop_skip_a: assert property ((r_reg.st == RTP_INFO && rec_valid && r_reg.ctrl[CTRL_DROP]
        && rec_data[RXERR_BIT]) |=> r_reg.st == RTP_SKIP && r_reg.drops == $past(r_reg.drops) + 16'h0001)
        else $error("errored record not dropped");
    one_port_a: assert property ((r_reg.st == RTP_PAY && $past(r_reg.st) == RTP_PAY) |-> $stable(r_reg.port))
        else $error("port changed inside a record");
    mem_reset_a: assert property ($rose(rst_n) |-> mem_tx_mb == TX_MB_RST
        && mem_rx_mb == MEM_TOTAL_MB - TX_MB_RST)
        else $error("memory split reset wrong");
    mem_locked_a: assert property ((busy || rx_active) |=> $stable(mem_tx_mb))
        else $error("memory split changed while active");
    no_spont_a: assert property (bq.valid |-> r_reg.st == RTP_PAY && r_reg.have)
        else $error("byte sent outside a record");
    wait_time_a: assert property ((r_reg.st == RTP_WAIT && r_reg.now < r_reg.ts) |=> r_reg.st == RTP_WAIT)
        else $error("record released before its timestamp");
    underrun_set_a: assert property (under_ev |=> r_reg.underrun [*2])
        else $error("underrun not held");
    time_adv_a: assert property (!(wr && (idx == 4'h4 || idx == 4'h5))
        |=> r_reg.now == $past(r_reg.now) + TIME_STEP)
        else $error("card time did not advance");
endmodule

// >>> tb/rtp_host_model.sv
// host memory model feeding record words to the transmit path
module rtp_host_model (
    // clock
    input  wire logic        clk,
    // record stream
    input  wire logic        rec_ready,
    output logic      [63:0] rec_data,
    output logic             rec_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] q[$];
    initial begin
        rec_data = 64'h0;
        rec_valid = 1'b0;
    end
    always @(posedge clk) begin
        if (rec_valid && rec_ready) begin
            void'(q.pop_front());
        end
        if (q.size() != 0) begin
            rec_data <= q[0];
            rec_valid <= 1'b1;
        end else begin
            rec_data <= ~rec_data;
            rec_valid <= 1'b0;
        end
    end
endmodule

// >>> tb/tb.sv
// self-checking bench of the record transmit path
module tb;
    import rtp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // clock, reset, wiring
    // ------------------------------------------------------------
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, rx_active = 1'b0;
    logic [7:0] adr = 8'h00, mac_data, tx_mb, rx_mb, got[$];
    logic [31:0] wdat = 32'h0, wb_dat_o;
    logic [63:0] rec_data, tstamp = 64'h0;
    logic rec_valid, rec_ready, wb_ack_o, mac_valid, mac_last, mrdy = 1'b1;
    logic [1:0] mac_port, last_port;
    int err_total = 0, tests_run = 0, cycles = 0, lastn = 0, fc = 0;
    always #20 clk = ~clk;
    rtp_host_model host (.clk(clk), .rec_ready(rec_ready), .rec_data(rec_data), .rec_valid(rec_valid));
    rtp_top dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rec_data(rec_data),
        .rec_valid(rec_valid), .rec_ready(rec_ready), .rx_active(rx_active), .link_up(4'hF),
        .mem_tx_mb(tx_mb), .mem_rx_mb(rx_mb), .mac_data(mac_data), .mac_valid(mac_valid),
        .mac_last(mac_last), .mac_port(mac_port), .mac_ready(mrdy));
    always @(posedge clk) begin
        if (mac_valid === 1'b1 && mrdy === 1'b1) begin
            if (got.size() == 0) fc = cycles;
            got.push_back(mac_data);
            if (mac_last === 1'b1) lastn = got.size();
            last_port <= mac_port;
        end
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            complete_run();
        end
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (wb_ack_o !== 1'b1) @(posedge clk);
        r = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic run(input logic [4:0] c, input logic [1:0] p, input logic e, input logic [15:0] wl,
                       input int n, input bit crc);
        logic [31:0] r, k;
        int i, j;
        wb(1'b1, OFS_CTRL, {27'h0, c}, r);
        got.delete();
        lastn = 0;
        host.q.push_back(tstamp);
        host.q.push_back({16'h0, wl, 16'h18, 3'h0, e, 2'h0, p, 8'h0});
        host.q.push_back(64'h0807060504030201);
        for (i = 0; i < 400 && host.q.size() != 0; i++) @(posedge clk);
        repeat (20) @(posedge clk);
        check(got.size(), n + (crc ? 4 : 0));
        check(lastn, n + (crc ? 4 : 0));
        k = CRC_INIT;
        for (i = 0; i < n; i++) begin
            check(got[i], i + 1);
            k = k ^ (i + 1);
            for (j = 0; j < 8; j++) k = k[0] ? (k >> 1) ^ CRC_POLY : k >> 1;
        end
        if (crc) check({got[n+3], got[n+2], got[n+1], got[n]}, ~k);
        if (n > 0) check(last_port, p);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_split();
        logic [31:0] r;
        wb(1'b0, OFS_MEMSPLIT, 32'h0, r);
        check(r, 32'h0000EF10);
        wb(1'b1, OFS_CTRL, 32'h1, r);
        wb(1'b1, OFS_MEMSPLIT, 32'h20, r);
        wb(1'b1, OFS_CTRL, 32'h0, r);
        rx_active <= 1'b1;
        wb(1'b1, OFS_MEMSPLIT, 32'h30, r);
        rx_active <= 1'b0;
        wb(1'b0, OFS_MEMSPLIT, 32'h0, r);
        check(r, 32'h0000EF10);
        wb(1'b1, OFS_MEMSPLIT, 32'h20, r);
        @(posedge clk);
        check({tx_mb, rx_mb}, 16'h20DF);
    endtask
    task automatic t_frames();
        run(5'h01, 2'h0, 1'b0, 16'h8, 8, 0);
        run(5'h03, 2'h3, 1'b0, 16'h8, 4, 0);
        run(5'h05, 2'h1, 1'b0, 16'h4, 4, 1);
        run(5'h07, 2'h2, 1'b0, 16'h8, 4, 1);
    endtask
    task automatic t_drop();
        logic [31:0] r;
        run(5'h09, 2'h1, 1'b1, 16'h8, 0, 0);
        wb(1'b0, OFS_DROPS, 32'h0, r);
        check(r, 32'h1);
        run(5'h01, 2'h2, 1'b1, 16'h8, 8, 0);
    endtask
    task automatic t_timed();
        logic [31:0] r;
        int t0;
        wb(1'b1, OFS_TFRAC, 32'h0, r);
        t0 = cycles;
        tstamp = 64'h0000000000008598;
        run(5'h11, 2'h3, 1'b0, 16'h8, 8, 0);
        tstamp = 64'h0;
        check((fc - t0) inside {[196:212]}, 1'b1);
    endtask
    task automatic t_under();
        logic [31:0] r;
        int i;
        wb(1'b1, OFS_CTRL, 32'h1, r);
        got.delete();
        lastn = 0;
        host.q.push_back(64'h0);
        host.q.push_back({16'h0, 16'h10, 16'h20, 16'h0});
        host.q.push_back(64'h0807060504030201);
        mrdy <= 1'b0;
        repeat (10) @(posedge clk);
        mrdy <= 1'b1;
        repeat (30) @(posedge clk);
        host.q.push_back(64'h100F0E0D0C0B0A09);
        repeat (40) @(posedge clk);
        check(got.size(), 16);
        check(lastn, 16);
        for (i = 0; i < 16; i++) check(got[i], i + 1);
        wb(1'b0, OFS_STATUS, 32'h0, r);
        check(r, 32'h00000F01);
        wb(1'b1, OFS_STATUS, 32'h1, r);
        wb(1'b0, OFS_STATUS, 32'h0, r);
        check(r, 32'h00000F00);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_split();
        t_frames();
        t_drop();
        t_timed();
        t_under();
        complete_run();
    end
endmodule
